// *** lssc_top.sv ***
/*
 * Command-side state of a power supply interface card: operating and trigger
 * modes, limit error flagging, and the current step list sequencer.
 * Assumes one decoded command per i_cmd_valid pulse, on this clock,
 * and one list value per append pulse.
 */
// Summary of operation
// (R1) Operating mode is voltage or current, reported 0 for voltage, 1 current.
// (R2) In voltage mode flag an error when load forces past current limit.
// (R3) In current mode flag an error when load forces past voltage limit.
// (R4) Mode select forces any transient programming style back to style_a.
// (R5) Separate trigger mode stored, entered on trigger, reported 0 or 1.
// (R6) Trigger mode is saved by save-setup and restored by recall-setup.
// (R7) Trigger mode select forces any transient programming style to style_a.
// (R8) List wipe zeroes pointers, order up, default sequence, repeat total one.
// (R9) List wipe also zeroes the lead step omit count.
// (R10) Repeat count 0 to 255 sets list executions and is readable.
// (R11) Repeat count zero runs endlessly until style_a voltage or program halt.
// (R12) Each repetition walks entries in the chosen traversal order.
// (R13) Omit count skips that many leading steps after the first pass.
// (R14) Lead step omission applies only when traversal order is up.
// (R15) Appended values fill consecutive locations from the fill pointer, 1002 max.
// (R16) Command buffer holds 253 characters; host splits long lists.
// (R17) Voltage list entries make append, readback, fill query post error -221.
// (R18) Readback returns up to 16 values from the readback start location.
// (R19) Fill pointer increments per value; query returns 0 to 1001.
// (R20) Host selects current mode before current list appends.
// (R21) Step hold is 0.5 ms to 10 s; a lone location zero applies everywhere.
// (R22) Traversal order selects first to last or last to first.
// (R23) Advance on hold expiry; hold last executed value after final repetition.
`timescale 1ns/10ps
module lssc_top #(
  parameter int HOLD_TICK_CYCLES = lssc_pkg::HOLD_TICK_CYCLES
) (
  // System
  input wire logic i_clock,
  input wire logic i_rst,
  // Decoded commands
  input wire logic i_cmd_valid,
  input wire lssc_pkg::lssc_cmd_t i_cmd,
  input wire logic [lssc_pkg::VALUE_W-1:0] i_cmd_arg,
  input wire logic [lssc_pkg::INDEX_W-1:0] i_readback_start,
  // Surroundings
  input wire logic i_voltage_list_used,
  input wire logic [lssc_pkg::HOLD_UNITS_W-1:0] i_hold_units,
  input wire logic [lssc_pkg::HOLD_UNITS_W-1:0] i_hold_units_loc0,
  input wire logic i_hold_loc0_only,
  // Analog limit pins
  input wire logic i_current_limit_hit,
  input wire logic i_voltage_limit_hit,
  // Mode and setting state
  output logic o_mode,
  output logic o_trig_mode,
  output logic o_active_mode,
  output lssc_pkg::lssc_style_t o_voltage_style,
  output lssc_pkg::lssc_style_t o_current_style,
  output logic o_limit_error,
  output logic [7:0] o_repeat_total,
  output logic [7:0] o_lead_step_omit,
  output logic o_traversal_order,
  output logic o_sequence_generation,
  // List run
  output logic o_run_active,
  output logic [lssc_pkg::INDEX_W-1:0] o_run_index,
  output logic [lssc_pkg::VALUE_W-1:0] o_step_value,
  // Query answers
  output logic o_rd_valid,
  output logic o_rd_last,
  output logic [lssc_pkg::VALUE_W-1:0] o_rd_data,
  output logic o_fill_valid,
  output logic [lssc_pkg::INDEX_W-1:0] o_fill_index,
  output logic o_err_valid,
  output logic [15:0] o_err_code
);
  import lssc_pkg::*;

  typedef enum logic [1:0] {
    RB_IDLE,
    RB_SEND
  } lssc_rb_t;

  typedef struct packed {
    logic [1:0] cur_sync;
    logic [1:0] volt_sync;
    logic mode;
    logic trig_mode;
    logic saved_trig_mode;
    logic active_mode;
    lssc_style_t vstyle;
    lssc_style_t cstyle;
    logic limit_error;
    logic [7:0] repeat_total;
    logic [7:0] omit;
    logic order;
    logic gen;
    logic [INDEX_W-1:0] fill;
    logic [LIST_DEPTH-1:0][VALUE_W-1:0] mem;
    logic running;
    logic [INDEX_W-1:0] run_index;
    logic [7:0] passes;
    logic [VALUE_W-1:0] step_value;
    logic hold_load;
    logic [HOLD_UNITS_W-1:0] hold_units;
    lssc_rb_t rb_state;
    logic [INDEX_W-1:0] rb_index;
    logic [4:0] rb_left;
    logic rd_valid;
    logic rd_last;
    logic [VALUE_W-1:0] rd_data;
    logic fill_valid;
    logic [INDEX_W-1:0] fill_index;
    logic err_valid;
    logic [15:0] err_code;
  } lssc_state_t;

  lssc_state_t st_reg;
  lssc_state_t st_next;
  lssc_hold_if hold_link ();

  // Last filled location
  function automatic logic [INDEX_W-1:0] last_loc(input logic [INDEX_W-1:0] fill);
    last_loc = fill - INDEX_ONE;
  endfunction : last_loc

  // Location zero's hold may cover every step
  function automatic logic [HOLD_UNITS_W-1:0] pick_hold(input logic only0,
      input logic [HOLD_UNITS_W-1:0] loc0, input logic [HOLD_UNITS_W-1:0] own);
    pick_hold = only0 ? loc0 : own;
  endfunction : pick_hold

  lssc_hold_timer #(
    .TICK_CYCLES(HOLD_TICK_CYCLES)
  ) u_hold_timer (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .hold(hold_link.timer)
  );

  assign hold_link.load = st_reg.hold_load;
  assign hold_link.units = st_reg.hold_units;

  always_comb begin
    st_next = st_reg;
    st_next.hold_load = 1'b0;
    st_next.rd_valid = 1'b0;
    st_next.rd_last = 1'b0;
    st_next.fill_valid = 1'b0;
    st_next.err_valid = 1'b0;

    // Two-flop sync for the limit pins
    st_next.cur_sync = {st_reg.cur_sync[0], i_current_limit_hit};
    st_next.volt_sync = {st_reg.volt_sync[0], i_voltage_limit_hit};
    if (st_reg.mode == MODE_VOLTAGE) begin
      st_next.limit_error = st_reg.cur_sync[1]; // see (R2)
    end else begin
      st_next.limit_error = st_reg.volt_sync[1]; // see (R3)
    end

    // Running list: step on hold expiry
    if (st_reg.running && hold_link.expire) begin // see (R23)
      if (st_reg.order == ORDER_UP) begin // see (R12) (R22)
        if (st_reg.run_index == last_loc(st_reg.fill)) begin
          if (st_reg.repeat_total != COUNT_ZERO
              && st_reg.passes + COUNT_ONE == st_reg.repeat_total) begin // see (R11)
            st_next.running = 1'b0; // see (R23)
          end else begin
            st_next.passes = st_reg.passes + COUNT_ONE;
            // Omit lead steps after first pass
            if ({2'b00, st_reg.omit} < st_reg.fill) begin // see (R13) (R14)
              st_next.run_index = {2'b00, st_reg.omit};
            end else begin
              st_next.run_index = INDEX_ZERO;
            end
          end
        end else begin
          st_next.run_index = st_reg.run_index + INDEX_ONE;
        end
      end else begin
        if (st_reg.run_index == INDEX_ZERO) begin
          if (st_reg.repeat_total != COUNT_ZERO
              && st_reg.passes + COUNT_ONE == st_reg.repeat_total) begin // see (R11)
            st_next.running = 1'b0;
          end else begin
            st_next.passes = st_reg.passes + COUNT_ONE;
            st_next.run_index = last_loc(st_reg.fill); // see (R14)
          end
        end else begin
          st_next.run_index = st_reg.run_index - INDEX_ONE;
        end
      end
      if (st_next.running) begin
        st_next.step_value = st_reg.mem[st_next.run_index];
        st_next.hold_load = 1'b1;
        st_next.hold_units = pick_hold(i_hold_loc0_only, i_hold_units_loc0,
            i_hold_units); // see (R21)
      end
    end

    // Readback stream, one value a cycle
    case (st_reg.rb_state)
      RB_IDLE: begin
      end
      RB_SEND: begin
        st_next.rd_valid = 1'b1;
        st_next.rd_data = st_reg.mem[st_reg.rb_index];
        st_next.rb_index = st_reg.rb_index + INDEX_ONE;
        st_next.rb_left = st_reg.rb_left - READBACK_ONE;
        if (st_reg.rb_left == READBACK_ONE
            || st_reg.rb_index == last_loc(st_reg.fill)) begin // see (R18)
          st_next.rd_last = 1'b1;
          st_next.rb_state = RB_IDLE;
        end
      end
      default: begin
        st_next.rb_state = RB_IDLE;
      end
    endcase

    if (i_cmd_valid) begin
      case (i_cmd)
        CMD_MODE_SELECT: begin
          st_next.mode = i_cmd_arg[0]; // see (R1)
          st_next.active_mode = i_cmd_arg[0];
          if (st_reg.vstyle == STYLE_TRANSIENT) begin
            st_next.vstyle = STYLE_A; // see (R4)
          end
          if (st_reg.cstyle == STYLE_TRANSIENT) begin
            st_next.cstyle = STYLE_A; // see (R4)
          end
        end
        CMD_TRIG_MODE_SELECT: begin
          st_next.trig_mode = i_cmd_arg[0]; // see (R5)
          if (st_reg.vstyle == STYLE_TRANSIENT) begin
            st_next.vstyle = STYLE_A; // see (R7)
          end
          if (st_reg.cstyle == STYLE_TRANSIENT) begin
            st_next.cstyle = STYLE_A; // see (R7)
          end
        end
        CMD_TRIGGER: begin
          st_next.active_mode = st_reg.trig_mode; // see (R5)
        end
        CMD_SAVE_SETUP: begin
          st_next.saved_trig_mode = st_reg.trig_mode; // see (R6)
        end
        CMD_RECALL_SETUP: begin
          st_next.trig_mode = st_reg.saved_trig_mode; // see (R6)
        end
        CMD_LIST_WIPE: begin
          st_next.fill = INDEX_ZERO; // see (R8)
          st_next.run_index = INDEX_ZERO;
          st_next.order = ORDER_UP;
          st_next.gen = GEN_DEFAULT_SEQUENCE;
          st_next.repeat_total = REPEAT_DEFAULT;
          st_next.omit = COUNT_ZERO; // see (R9)
          st_next.running = 1'b0;
        end
        CMD_REPEAT_TOTAL: begin
          st_next.repeat_total = i_cmd_arg[7:0]; // see (R10)
        end
        CMD_LEAD_STEP_OMIT: begin
          st_next.omit = i_cmd_arg[7:0]; // see (R13)
        end
        CMD_CURRENT_APPEND: begin
          // One value per pulse (see (R16))
          if (i_voltage_list_used) begin
            st_next.err_valid = 1'b1; // see (R17)
            st_next.err_code = ERR_SETTINGS_CONFLICT;
          end else if (st_reg.fill < LIST_DEPTH) begin
            st_next.mem[st_reg.fill] = i_cmd_arg; // see (R15)
            st_next.fill = st_reg.fill + INDEX_ONE; // see (R19)
          end
        end
        CMD_CURRENT_READBACK: begin
          if (i_voltage_list_used) begin
            st_next.err_valid = 1'b1; // see (R17)
            st_next.err_code = ERR_SETTINGS_CONFLICT;
          end else if (i_readback_start < st_reg.fill
              && st_reg.rb_state == RB_IDLE) begin
            st_next.rb_state = RB_SEND; // see (R18)
            st_next.rb_index = i_readback_start;
            st_next.rb_left = READBACK_MAX;
          end
        end
        CMD_FILL_INDEX_QUERY: begin
          if (i_voltage_list_used) begin
            st_next.err_valid = 1'b1; // see (R17)
            st_next.err_code = ERR_SETTINGS_CONFLICT;
          end else begin
            st_next.fill_valid = 1'b1;
            st_next.fill_index = (st_reg.fill > FILL_QUERY_MAX) ? FILL_QUERY_MAX
                : st_reg.fill; // see (R19)
          end
        end
        CMD_TRAVERSAL_ORDER: begin
          st_next.order = i_cmd_arg[0]; // see (R22)
        end
        CMD_VOLTAGE_STYLE, CMD_CURRENT_STYLE: begin
          if (i_cmd == CMD_VOLTAGE_STYLE) begin
            st_next.vstyle = lssc_style_t'(i_cmd_arg[1:0]);
          end else begin
            st_next.cstyle = lssc_style_t'(i_cmd_arg[1:0]);
          end
          if (lssc_style_t'(i_cmd_arg[1:0]) == STYLE_LIST
              && st_reg.fill != INDEX_ZERO) begin
            st_next.running = 1'b1;
            st_next.passes = COUNT_ZERO;
            st_next.run_index = (st_reg.order == ORDER_UP) ? INDEX_ZERO
                : last_loc(st_reg.fill); // see (R12)
            st_next.step_value = st_reg.mem[st_next.run_index];
            st_next.hold_load = 1'b1;
            st_next.hold_units = pick_hold(i_hold_loc0_only, i_hold_units_loc0,
                i_hold_units); // see (R21)
          end else if (i_cmd == CMD_VOLTAGE_STYLE
              && lssc_style_t'(i_cmd_arg[1:0]) == STYLE_A) begin
            st_next.running = 1'b0; // see (R11)
          end
        end
        CMD_PROGRAM_HALT: begin
          st_next.running = 1'b0; // see (R11)
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.repeat_total <= REPEAT_DEFAULT;
      st_reg.rb_state <= RB_IDLE;
      st_reg.vstyle <= STYLE_A;
      st_reg.cstyle <= STYLE_A;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_mode = st_reg.mode;
  assign o_trig_mode = st_reg.trig_mode;
  assign o_active_mode = st_reg.active_mode;
  assign o_voltage_style = st_reg.vstyle;
  assign o_current_style = st_reg.cstyle;
  assign o_limit_error = st_reg.limit_error;
  assign o_repeat_total = st_reg.repeat_total;
  assign o_lead_step_omit = st_reg.omit;
  assign o_traversal_order = st_reg.order;
  assign o_sequence_generation = st_reg.gen;
  assign o_run_active = st_reg.running;
  assign o_run_index = st_reg.run_index;
  assign o_step_value = st_reg.step_value;
  assign o_rd_valid = st_reg.rd_valid;
  assign o_rd_last = st_reg.rd_last;
  assign o_rd_data = st_reg.rd_data;
  assign o_fill_valid = st_reg.fill_valid;
  assign o_fill_index = st_reg.fill_index;
  assign o_err_valid = st_reg.err_valid;
  assign o_err_code = st_reg.err_code;

endmodule : lssc_top

// *** lssc_pkg.sv ***
/*
 * Shared constants and types for the list step sequencer control block.
 * Assumes a 100 MHz system clock and one asynchronous active-high reset.
 */
package lssc_pkg;

  // Clock and step hold timing
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int HOLD_UNIT_NS = 500000;
  localparam int HOLD_TICK_CYCLES = HOLD_UNIT_NS / CLOCK_PERIOD_NS;
  localparam int HOLD_UNITS_W = 15;
  localparam logic [HOLD_UNITS_W-1:0] HOLD_UNITS_MIN = 15'h0001;
  localparam logic [HOLD_UNITS_W-1:0] HOLD_UNITS_MAX = 15'h4e20;

  // List geometry
  localparam int VALUE_W = 16;
  localparam int INDEX_W = 10;
  localparam logic [INDEX_W-1:0] LIST_DEPTH = 10'h3ea;
  localparam logic [INDEX_W-1:0] FILL_QUERY_MAX = 10'h3e9;
  localparam logic [INDEX_W-1:0] INDEX_ZERO = 10'h000;
  localparam logic [INDEX_W-1:0] INDEX_ONE = 10'h001;
  localparam logic [4:0] READBACK_MAX = 5'h10;
  localparam logic [4:0] READBACK_ONE = 5'h01;

  // Counts
  localparam logic [7:0] REPEAT_DEFAULT = 8'h01;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // Error queue code: settings conflict
  localparam logic [15:0] ERR_SETTINGS_CONFLICT = 16'hff23;

  // Mode encodings as reported on query
  localparam logic MODE_VOLTAGE = 1'b0;
  localparam logic MODE_CURRENT = 1'b1;
  localparam logic ORDER_UP = 1'b0;
  localparam logic ORDER_DOWN = 1'b1;
  localparam logic GEN_DEFAULT_SEQUENCE = 1'b0;

  typedef enum logic [1:0] {
    STYLE_A,
    STYLE_LIST,
    STYLE_TRANSIENT
  } lssc_style_t;

  typedef enum logic [3:0] {
    CMD_MODE_SELECT,
    CMD_TRIG_MODE_SELECT,
    CMD_TRIGGER,
    CMD_SAVE_SETUP,
    CMD_RECALL_SETUP,
    CMD_LIST_WIPE,
    CMD_REPEAT_TOTAL,
    CMD_LEAD_STEP_OMIT,
    CMD_CURRENT_APPEND,
    CMD_CURRENT_READBACK,
    CMD_FILL_INDEX_QUERY,
    CMD_TRAVERSAL_ORDER,
    CMD_VOLTAGE_STYLE,
    CMD_CURRENT_STYLE,
    CMD_PROGRAM_HALT
  } lssc_cmd_t;

endpackage : lssc_pkg

// *** lssc_hold_if.sv ***
/*
 * Link between the sequencer and its step hold timer.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/10ps
interface lssc_hold_if;
  import lssc_pkg::*;
  logic load;
  logic [HOLD_UNITS_W-1:0] units;
  logic expire;
  modport seq (output load, output units, input expire);
  modport timer (input load, input units, output expire);
endinterface : lssc_hold_if

// *** lssc_hold_timer.sv ***
/*
 * Step hold timer: counts hold time in 0.5 ms units and pulses expire once.
 * Assumes a load pulse starts or restarts a hold.
 */
`timescale 1ns/10ps
module lssc_hold_timer #(
  parameter int TICK_CYCLES = lssc_pkg::HOLD_TICK_CYCLES
) (
  // System
  input wire logic i_clock,
  input wire logic i_rst,
  // Sequencer side
  lssc_hold_if.timer hold
);
  import lssc_pkg::*;

  typedef struct packed {
    logic running;
    logic [HOLD_UNITS_W-1:0] left;
    logic [16:0] div;
    logic expire;
  } lssc_timer_state_t;

  lssc_timer_state_t st_reg;
  lssc_timer_state_t st_next;
  logic tick;

  assign tick = (st_reg.div == 17'(TICK_CYCLES - 1));
  assign hold.expire = st_reg.expire;

  always_comb begin
    st_next = st_reg;
    st_next.expire = 1'b0;
    if (hold.load) begin
      st_next.running = 1'b1;
      st_next.div = 17'h00000;
      // Clamp to the legal hold range
      if (hold.units < HOLD_UNITS_MIN) begin
        st_next.left = HOLD_UNITS_MIN;
      end else if (hold.units > HOLD_UNITS_MAX) begin
        st_next.left = HOLD_UNITS_MAX;
      end else begin
        st_next.left = hold.units;
      end
    end else if (st_reg.running) begin
      st_next.div = tick ? 17'h00000 : st_reg.div + 17'h00001;
      if (tick) begin
        if (st_reg.left == HOLD_UNITS_MIN) begin
          st_next.running = 1'b0;
          st_next.expire = 1'b1;
        end else begin
          st_next.left = st_reg.left - HOLD_UNITS_MIN;
        end
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : lssc_hold_timer

// *** lssc_top_chk.sv ***
/* Port assertions for lssc_top.
   Bound from the bench; sees top ports only. */
`timescale 1ns/10ps
module lssc_top_chk (
  // System
  input wire logic i_clock,
  input wire logic i_rst,
  // Inputs
  input wire logic i_cmd_valid,
  input wire lssc_pkg::lssc_cmd_t i_cmd,
  input wire logic [lssc_pkg::VALUE_W-1:0] i_cmd_arg,
  input wire logic i_current_limit_hit,
  input wire logic i_voltage_limit_hit,
  // Outputs
  input wire logic o_mode,
  input wire logic o_trig_mode,
  input wire logic o_active_mode,
  input wire lssc_pkg::lssc_style_t o_voltage_style,
  input wire lssc_pkg::lssc_style_t o_current_style,
  input wire logic o_limit_error,
  input wire logic [7:0] o_repeat_total,
  input wire logic [7:0] o_lead_step_omit,
  input wire logic o_traversal_order,
  input wire logic o_sequence_generation
);
  import lssc_pkg::*;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);

  sequence s_cmd(lssc_cmd_t c);
    i_cmd_valid && i_cmd == c;
  endsequence
  // Mode held over the sync path
  sequence s_held(logic m);
    (o_mode == m) [*4];
  endsequence
  sequence s_no_transient_style;
    o_voltage_style != STYLE_TRANSIENT && o_current_style != STYLE_TRANSIENT;
  endsequence

  property p_wipe;
    s_cmd(CMD_LIST_WIPE) |=> o_repeat_total == REPEAT_DEFAULT && o_lead_step_omit == COUNT_ZERO
      && o_traversal_order == ORDER_UP && o_sequence_generation == GEN_DEFAULT_SEQUENCE;
  endproperty
  a_wipe: assert property (p_wipe) else $error("wipe bad");
  property p_repeat;
    s_cmd(CMD_REPEAT_TOTAL) |=> o_repeat_total == $past(i_cmd_arg[7:0]);
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat bad");
  property p_omit;
    s_cmd(CMD_LEAD_STEP_OMIT) |=> o_lead_step_omit == $past(i_cmd_arg[7:0]);
  endproperty
  a_omit: assert property (p_omit) else $error("omit bad");
  property p_mode;
    s_cmd(CMD_MODE_SELECT) |=> o_mode == $past(i_cmd_arg[0]) && o_active_mode == o_mode ##0 s_no_transient_style;
  endproperty
  a_mode: assert property (p_mode) else $error("mode bad");
  property p_trig_sel;
    s_cmd(CMD_TRIG_MODE_SELECT) |=> o_trig_mode == $past(i_cmd_arg[0]) ##0 s_no_transient_style;
  endproperty
  a_trig_sel: assert property (p_trig_sel) else $error("trig sel bad");
  property p_trigger;
    s_cmd(CMD_TRIGGER) |=> o_active_mode == $past(o_trig_mode);
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger bad");
  property p_limit_v;
    s_held(MODE_VOLTAGE) |-> o_limit_error == $past(i_current_limit_hit, 3);
  endproperty
  a_limit_v: assert property (p_limit_v) else $error("v limit bad");
  property p_limit_c;
    s_held(MODE_CURRENT) |-> o_limit_error == $past(i_voltage_limit_hit, 3);
  endproperty
  a_limit_c: assert property (p_limit_c) else $error("c limit bad");
endmodule : lssc_top_chk

// *** lssc_host_model.sv ***
/* Host model: one decoded command per send call.
   Assumes the bench clocks it and calls its tasks. */
`timescale 1ns/10ps
module lssc_host_model (
  // System
  input wire logic i_clock,
  // Command port
  output logic o_cmd_valid,
  output lssc_pkg::lssc_cmd_t o_cmd,
  output logic [lssc_pkg::VALUE_W-1:0] o_cmd_arg,
  output logic [lssc_pkg::INDEX_W-1:0] o_readback_start
);
  import lssc_pkg::*;
  logic host_mode = MODE_VOLTAGE;
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = CMD_PROGRAM_HALT;
    o_cmd_arg = 16'h0000;
    o_readback_start = 10'h000;
  end
  // Idle argument lines show inverse values
  task automatic send(input lssc_cmd_t c, input logic [15:0] a, input logic [9:0] s);
    @(posedge i_clock);
    o_cmd_valid <= 1'b1;
    o_cmd <= c;
    o_cmd_arg <= a;
    o_readback_start <= s;
    if (c == CMD_MODE_SELECT) host_mode = a[0];
    @(posedge i_clock);
    o_cmd_valid <= 1'b0;
    o_cmd_arg <= ~a;
    o_readback_start <= ~s;
  endtask : send
  // One value per command fits the input buffer
  task automatic put_current(input logic [15:0] v);
    if (host_mode !== MODE_CURRENT) send(CMD_MODE_SELECT, 16'h0001, 10'h000);
    send(CMD_CURRENT_APPEND, v, 10'h000);
  endtask : put_current
endmodule : lssc_host_model

// *** lssc_top_bench.sv ***
/* Self-checking bench for lssc_top.
   Assumes all block files are compiled first. */
`timescale 1ns/10ps
module lssc_top_bench;
  import lssc_pkg::*;
  logic i_clock, i_rst, i_cmd_valid, i_voltage_list_used, i_hold_loc0_only;
  logic i_current_limit_hit, i_voltage_limit_hit, prev_act;
  lssc_cmd_t i_cmd;
  logic [VALUE_W-1:0] i_cmd_arg, o_step_value, o_rd_data, o_err_code;
  logic [INDEX_W-1:0] i_readback_start, o_run_index, o_fill_index, prev_idx;
  logic [HOLD_UNITS_W-1:0] i_hold_units, i_hold_units_loc0;
  logic o_mode, o_trig_mode, o_active_mode, o_limit_error, o_traversal_order;
  logic o_sequence_generation, o_run_active, o_rd_valid, o_rd_last, o_fill_valid, o_err_valid;
  lssc_style_t o_voltage_style, o_current_style;
  logic [7:0] o_repeat_total, o_lead_step_omit;
  logic [15:0] mem[$], stepq[$];
  logic [16:0] rdq[$];
  logic [INDEX_W-1:0] idxq[$];
  logic hc[24], hv[24];
  lssc_cmd_t ecmd[3] = '{CMD_CURRENT_APPEND, CMD_CURRENT_READBACK, CMD_FILL_INDEX_QUERY};
  int err_total, num_checks, seed;

  lssc_host_model i_host (.i_clock, .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd),
    .o_cmd_arg(i_cmd_arg), .o_readback_start(i_readback_start));
  lssc_top #(.HOLD_TICK_CYCLES(4)) i_dut (.*);

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // Log readback beats and run steps
  always @(posedge i_clock) begin
    if (o_rd_valid) rdq.push_back({o_rd_last, o_rd_data});
    if (o_run_active && (!prev_act || o_run_index !== prev_idx)) begin
      idxq.push_back(o_run_index);
      stepq.push_back(o_step_value);
    end
    prev_act <= o_run_active;
    prev_idx <= o_run_index;
  end

  task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic cmd(input lssc_cmd_t c, input logic [15:0] a);
    i_host.send(c, a, 10'h000);
    @(negedge i_clock);
  endtask : cmd

  task automatic readback(input int s);
    int n;
    n = (mem.size() - s > 16) ? 16 : ((mem.size() > s) ? mem.size() - s : 0);
    rdq = {};
    i_host.send(CMD_CURRENT_READBACK, 16'h0000, 10'(s));
    repeat (24) @(negedge i_clock);
    chk("rb beats", 17'(n), 17'(rdq.size()));
    for (int k = 0; k < n; k++) chk("readback", {k == n - 1, mem[s + k]}, rdq[k]);
  endtask : readback

  task automatic run_list(input int rep, input int omit, input logic down);
    logic [INDEX_W-1:0] exp[$];
    int n, t, st;
    n = mem.size();
    cmd(CMD_TRAVERSAL_ORDER, 16'(down));
    cmd(CMD_REPEAT_TOTAL, 16'(rep));
    cmd(CMD_LEAD_STEP_OMIT, 16'(omit));
    for (int p = 0; p < rep; p++) begin
      st = (p > 0 && !down && omit < n) ? omit : 0;
      for (int k = st; k < n; k++) exp.push_back(10'(down ? n - 1 - k : k));
    end
    idxq = {};
    stepq = {};
    cmd(CMD_CURRENT_STYLE, 16'(STYLE_LIST));
    t = 0;
    while (o_run_active === 1'b1 && t < 3000) begin
      @(negedge i_clock);
      t++;
    end
    chk("run steps", 17'(exp.size()), 17'(idxq.size()));
    foreach (exp[i]) begin
      chk("run index", exp[i], idxq[i]);
      chk("run value", mem[exp[i]], stepq[i]);
    end
    chk("final value", mem[exp[$]], o_step_value);
  endtask : run_list

  initial begin
    #200000;
    err_total++;
    test_done();
  end

  initial begin
    logic [7:0] v;
    seed = 59;
    err_total = 0;
    num_checks = 0;
    prev_act = 1'b0;
    prev_idx = 10'h000;
    i_rst = 1'b1;
    i_voltage_list_used = 1'b0;
    i_hold_units = 15'h0001;
    i_hold_units_loc0 = 15'h0001;
    i_hold_loc0_only = 1'b0;
    i_current_limit_hit = 1'b0;
    i_voltage_limit_hit = 1'b0;
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    chk("reset repeat", REPEAT_DEFAULT, o_repeat_total);
    for (int m = 0; m < 2; m++) begin
      cmd(CMD_VOLTAGE_STYLE, 16'(STYLE_TRANSIENT));
      cmd(CMD_CURRENT_STYLE, 16'(STYLE_LIST));
      cmd(CMD_MODE_SELECT, 16'(m));
      chk("mode", 17'(m), o_mode);
      chk("v style", STYLE_A, o_voltage_style);
      chk("c style", STYLE_LIST, o_current_style);
      cmd(CMD_CURRENT_STYLE, 16'(STYLE_TRANSIENT));
      cmd(CMD_TRIG_MODE_SELECT, 16'(1 - m));
      chk("trig mode", 17'(1 - m), o_trig_mode);
      chk("c style", STYLE_A, o_current_style);
      cmd(CMD_TRIGGER, 16'h0);
      chk("act mode", 17'(1 - m), o_active_mode);
    end
    cmd(CMD_TRIG_MODE_SELECT, 16'h1);
    cmd(CMD_SAVE_SETUP, 16'h0);
    cmd(CMD_TRIG_MODE_SELECT, 16'h0);
    cmd(CMD_RECALL_SETUP, 16'h0);
    chk("recalled trig", 1'b1, o_trig_mode);
    for (int m = 0; m < 2; m++) begin
      cmd(CMD_MODE_SELECT, 16'(m));
      for (int i = 0; i < 24; i++) begin
        hc[i] = 1'($random(seed));
        hv[i] = 1'($random(seed));
        @(posedge i_clock);
        i_current_limit_hit <= hc[i];
        i_voltage_limit_hit <= hv[i];
        @(negedge i_clock);
        if (i >= 3) chk("limit error", m ? hv[i - 3] : hc[i - 3], o_limit_error);
      end
    end
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      cmd(CMD_REPEAT_TOTAL, {8'h00, v});
      chk("repeat total", v, o_repeat_total);
      cmd(CMD_LEAD_STEP_OMIT, {8'h00, ~v});
      chk("omit", 8'(~v), o_lead_step_omit);
    end
    cmd(CMD_TRAVERSAL_ORDER, 16'h1);
    cmd(CMD_LIST_WIPE, 16'h0);
    chk("wipe repeat", 17'h1, o_repeat_total);
    chk("wipe omit", 17'h0, o_lead_step_omit);
    chk("wipe order", ORDER_UP, o_traversal_order);
    chk("wipe gen", GEN_DEFAULT_SEQUENCE, o_sequence_generation);
    cmd(CMD_MODE_SELECT, 16'(MODE_CURRENT));
    for (int i = 0; i < 20; i++) begin
      mem.push_back(16'($random(seed)));
      i_host.put_current(mem[i]);
    end
    @(posedge i_clock);
    i_voltage_list_used <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      cmd(ecmd[i], 16'h0);
      chk("err post", 1'b1, o_err_valid);
      chk("err code", ERR_SETTINGS_CONFLICT, o_err_code);
      chk("fill answer", 1'b0, o_fill_valid);
    end
    @(posedge i_clock);
    i_voltage_list_used <= 1'b0;
    cmd(CMD_FILL_INDEX_QUERY, 16'h0);
    chk("fill valid", 17'h1, o_fill_valid);
    chk("fill index", 17'(mem.size()), o_fill_index);
    readback(2);
    readback(12);
    readback(20);
    run_list(2, 3, 1'b0);
    run_list(2, 3, 1'b1);
    for (int j = 0; j < 2; j++) begin
      cmd(CMD_REPEAT_TOTAL, 16'h0000);
      cmd(CMD_CURRENT_STYLE, 16'(STYLE_LIST));
      repeat (400) @(negedge i_clock);
      chk("endless run", 17'h1, o_run_active);
      if (j == 0) cmd(CMD_PROGRAM_HALT, 16'h0000);
      else cmd(CMD_VOLTAGE_STYLE, 16'(STYLE_A));
      chk("run stopped", 17'h0, o_run_active);
    end
    test_done();
  end
endmodule : lssc_top_bench

bind lssc_top lssc_top_chk i_chk (.*);
